// file: shared/phy_led_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Register index space of 32 sixteen-bit registers
// Notes:   Byte address of a register is four times its index
`ifndef PHY_LED_CFG_SVH
`define PHY_LED_CFG_SVH

// Register indexes
`define LED_BEHAVIOR_IDX    5'h1e
`define PAGE_SELECT_IDX     5'h1f
`define PAGED_LO_IDX        5'h10
`define P1_IDX_A            5'h12
`define P1_IDX_B            5'h13
`define P1_IDX_C            5'h14
`define P1_IDX_D            5'h17
`define P1_IDX_E            5'h1d
`define P1_IDX_F            5'h1e
`define P1_COUNT            6

// Behaviour register fields
`define LED_ACTSEL_BIT      14
`define LED_PULSE_BIT       12
`define LED_RATE_LSB        10
`define LED_STRETCH_LSB     5
`define LED_COMB_LSB        0
`define LED_BEHAVIOR_RESET  16'h0400
`define LED_BEHAVIOR_WMASK  16'h5def

// Page select values
`define PAGE_MAIN           16'h0000
`define PAGE_EXT1           16'h0001
`define PAGE_EXT2           16'h0002

// Timing: fastest half blink period is 25 ms (20 Hz blink, 50 ms stretch)
`define CLK_MHZ             100
`define UNIT_MS             25
`define UNIT_CYCLES         (`UNIT_MS * `CLK_MHZ * 1000)

`endif

// file: shared/phy_led_pkg.sv
// Purpose: Types shared by the register bank and the LED shaper
// Assumes: Constants come from phy_led_cfg.svh
// Notes:   No constants here, only types
package phy_led_pkg;

    // LED behaviour settings decoded from the behaviour register
    typedef struct packed {
        logic       act_select;
        logic       pulsing_en;
        logic [1:0] rate;
        logic [3:0] stretch_en;
        logic [3:0] comb_dis;
    } led_cfg_s;

    // Where a register access lands
    typedef enum logic [2:0] {
        route_led,
        route_page,
        route_p1,
        route_ext,
        route_none
    } route_e;

    // Access forwarded to registers kept outside this bank
    typedef struct packed {
        logic        we;
        logic [1:0]  page;
        logic [4:0]  index;
        logic [15:0] wdata;
    } ext_req_s;

endpackage

// file: logic/led_shaper.sv
// Purpose: Blink and pulse-stretch shaping of four activity indications
// Assumes: Activity inputs come from logic on hclk
// Notes:   One prescaler is shared; each LED keeps its own hold counter
`timescale 1ns/1ps
`include "phy_led_cfg.svh"

module led_shaper #(
    parameter int N           = 4,
    parameter int UNIT_CYCLES = `UNIT_CYCLES
) (
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    input  wire phy_led_pkg::led_cfg_s   cfg,
    input  wire logic [N-1:0]            act_in,
    output logic [N-1:0]                 shaped
);
    localparam int PW = $clog2(UNIT_CYCLES + 1);

    logic [PW-1:0] pre_reg;
    logic          unit_tick;
    logic [3:0]    half_units;
    logic [3:0]    phase_cnt_reg;
    logic          blink_phase_reg;

    // Half blink period in units: rate 00 gives 8, rate 11 gives 1
    assign half_units = 4'h1 << (2'h3 - cfg.rate);
    assign unit_tick  = (pre_reg == PW'(UNIT_CYCLES - 1));

    // Unit prescaler
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_reg <= '0;
        end else if (unit_tick) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= pre_reg + PW'(1);
        end
    end

    // Free-running blink phase, toggles every half period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_cnt_reg   <= 4'h0;
            blink_phase_reg <= 1'b0;
        end else if (unit_tick) begin
            if (phase_cnt_reg + 4'h1 >= half_units) begin
                phase_cnt_reg   <= 4'h0;
                blink_phase_reg <= ~blink_phase_reg;
            end else begin
                phase_cnt_reg <= phase_cnt_reg + 4'h1;
            end
        end
    end

    // Per-LED hold: stretch length is one full blink period
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : gen_led
            logic [4:0] hold_reg;
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    hold_reg <= 5'h00;
                end else if (act_in[g]) begin
                    hold_reg <= {half_units, 1'b0};
                end else if (unit_tick && hold_reg != 5'h00) begin
                    hold_reg <= hold_reg - 5'h01;
                end
            end
            // Stretch holds steady, blink gates with the phase
            assign shaped[g] = (hold_reg != 5'h00) &&
                               (cfg.stretch_en[g] || blink_phase_reg);
        end
    endgenerate

endmodule

// file: logic/phy_led_regs.sv
// Purpose: LED behaviour and page select registers with paged routing
// Assumes: AHB-Lite single word transfers; one slave owns the bus
// Notes:   Byte address is four times the register index
// Notes:   Main page 0-29 and page 2 live outside, reached via ext port
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
`include "phy_led_cfg.svh"

module phy_led_regs #(
    parameter int UNIT_CYCLES = `UNIT_CYCLES,
    parameter int NLED        = 4
) (
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic                         hreadyout,
    output logic                         hresp,
    output logic [31:0]                  hrdata,
    output logic                         ext_valid,
    output phy_led_pkg::ext_req_s        ext_req,
    input  wire logic [15:0]             ext_rdata,
    input  wire logic [NLED-1:0]         primary_ind,
    input  wire logic [NLED-1:0]         secondary_ind,
    output phy_led_pkg::led_cfg_s        led_cfg,
    output logic [15:0]                  page_sel,
    output logic                         indicator_pin_a,
    output logic                         indicator_pin_b,
    output logic                         indicator_pin_c,
    output logic                         indicator_pin_d
);

    typedef enum logic [1:0] {
        st_idle,
        st_write,
        st_read_wait,
        st_read_done
    } bus_state_e;

    bus_state_e              state_reg;
    bus_state_e              state_next;
    logic [4:0]              idx_reg;
    logic                    mapped_reg;
    logic [15:0]             led_behavior_reg;
    logic [15:0]             page_reg;
    logic [15:0]             p1_regs [`P1_COUNT];
    logic [31:0]             hrdata_reg;
    logic [NLED-1:0]         pins_reg;
    logic [NLED-1:0]         shaped;
    logic                    take;
    phy_led_pkg::route_e     route;
    logic [2:0]              p1_slot;
    logic                    wr_commit;
    logic                    rd_fetch;
    logic [15:0]             rd_value;
    logic                    wr_led;
    logic                    wr_page;
    logic                    wr_p1;

    // Route an index under the current page
    function automatic phy_led_pkg::route_e route_of(
        input logic [15:0] page,
        input logic [4:0]  idx,
        input logic        mapped
    );
        phy_led_pkg::route_e r;
        r = phy_led_pkg::route_none;
        if (!mapped) begin
            r = phy_led_pkg::route_none;
        end else if (idx == `PAGE_SELECT_IDX) begin
            r = phy_led_pkg::route_page;
        end else if (idx < `PAGED_LO_IDX) begin
            r = phy_led_pkg::route_ext;
        end else if (page == `PAGE_MAIN) begin
            // Back on the main page after a zero write
            r = (idx == `LED_BEHAVIOR_IDX) ? phy_led_pkg::route_led
                                           : phy_led_pkg::route_ext;
        end else if (page == `PAGE_EXT1) begin
            r = phy_led_pkg::route_p1;
        end else if (page == `PAGE_EXT2) begin
            r = phy_led_pkg::route_ext;
        end else begin
            // Reserved page values reach nothing at indexes 16 to 30
            r = phy_led_pkg::route_none;
        end
        return r;
    endfunction

    // Slot of an implemented page 1 register, or P1_COUNT when reserved
    function automatic logic [2:0] p1_slot_of(input logic [4:0] idx);
        logic [2:0] s;
        s = 3'(`P1_COUNT);
        unique case (idx)
            `P1_IDX_A: s = 3'h0;
            `P1_IDX_B: s = 3'h1;
            `P1_IDX_C: s = 3'h2;
            `P1_IDX_D: s = 3'h3;
            `P1_IDX_E: s = 3'h4;
            `P1_IDX_F: s = 3'h5;
            default:   s = 3'(`P1_COUNT);
        endcase
        return s;
    endfunction

    // Address phase accepted only on a NONSEQ or SEQ with hready high
    assign take = hsel && htrans[1] && hready;

    // Data phase that follows an address phase, idle when none was taken
    function automatic bus_state_e phase_after(
        input logic accepted,
        input logic is_write
    );
        bus_state_e n;
        n = st_idle;
        if (accepted) begin
            n = is_write ? st_write : st_read_wait;
        end
        return n;
    endfunction

    // Bus sequencer: writes take no wait, reads take one
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            st_idle: begin
                state_next = phase_after(take, hwrite);
            end
            st_write: begin
                // Back to back: next address phase overlaps this data phase
                state_next = phase_after(take, hwrite);
            end
            st_read_wait: begin
                // Wait cycle holds hready low, so no address phase is taken
                state_next = st_read_done;
            end
            st_read_done: begin
                state_next = phase_after(take, hwrite);
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= st_idle;
        end else begin
            state_reg <= state_next;
        end
    end

    // Capture the index of the accepted address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx_reg    <= 5'h00;
            mapped_reg <= 1'b0;
        end else if (take) begin
            idx_reg    <= haddr[6:2];
            mapped_reg <= (haddr[31:7] == 25'h0000000) && (haddr[1:0] == 2'h0);
        end
    end

    // Routing uses the page held during the data phase
    assign route     = route_of(page_reg, idx_reg, mapped_reg);
    assign p1_slot   = p1_slot_of(idx_reg);
    assign wr_commit = (state_reg == st_write);
    assign rd_fetch  = (state_reg == st_read_wait);

    // Strobe of a data phase that lands on one register owner
    function automatic logic strobe_to(
        input logic                strobe,
        input phy_led_pkg::route_e now,
        input phy_led_pkg::route_e target
    );
        return strobe && (now == target);
    endfunction

    // Write strobes; reserved page 1 slots take no write
    assign wr_led  = strobe_to(wr_commit, route, phy_led_pkg::route_led);
    assign wr_page = strobe_to(wr_commit, route, phy_led_pkg::route_page);
    assign wr_p1   = strobe_to(wr_commit, route, phy_led_pkg::route_p1) &&
                     (p1_slot < 3'(`P1_COUNT));

    // Bus handshake: always OKAY, wait only in the first read cycle
    assign hreadyout = !rd_fetch;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;

    // LED behaviour register; only writable bits change
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            led_behavior_reg <= `LED_BEHAVIOR_RESET;
        end else if (wr_led) begin
            led_behavior_reg <= hwdata[15:0] & `LED_BEHAVIOR_WMASK;
        end
    end

    // Page select register, reachable on every page
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            page_reg <= `PAGE_MAIN;
        end else if (wr_page) begin
            // Reserved values are stored as written; routing ignores them
            page_reg <= hwdata[15:0];
        end
    end

    // Page 1 storage; contents are plain read/write words here
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < `P1_COUNT; i++) begin
                p1_regs[i] <= 16'h0000;
            end
        end else if (wr_p1) begin
            p1_regs[p1_slot] <= hwdata[15:0];
        end
    end

    // Forward main page and page 2 accesses; pulse for one cycle
    assign ext_valid     = strobe_to(wr_commit || rd_fetch, route, phy_led_pkg::route_ext);
    assign ext_req.we    = wr_commit;
    assign ext_req.page  = (idx_reg < `PAGED_LO_IDX) ? 2'h0 : page_reg[1:0];
    assign ext_req.index = idx_reg;
    assign ext_req.wdata = hwdata[15:0];

    // Read value selection by route
    always_comb begin
        rd_value = 16'h0000;
        unique case (route)
            phy_led_pkg::route_led:  rd_value = led_behavior_reg;
            phy_led_pkg::route_page: rd_value = page_reg;
            phy_led_pkg::route_p1: begin
                rd_value = (p1_slot < 3'(`P1_COUNT)) ? p1_regs[p1_slot] : 16'h0000;
            end
            phy_led_pkg::route_ext:  rd_value = ext_rdata;
            phy_led_pkg::route_none: rd_value = 16'h0000;
        endcase
    end

    // Read data registered at the end of the wait cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h00000000;
        end else if (rd_fetch) begin
            hrdata_reg <= {16'h0000, rd_value};
        end
    end

    // Decoded behaviour settings for the LED path
    assign led_cfg.act_select = led_behavior_reg[`LED_ACTSEL_BIT];
    assign led_cfg.pulsing_en = led_behavior_reg[`LED_PULSE_BIT];
    assign led_cfg.rate       = led_behavior_reg[`LED_RATE_LSB +: 2];
    assign led_cfg.stretch_en = led_behavior_reg[`LED_STRETCH_LSB +: 4];
    assign led_cfg.comb_dis   = led_behavior_reg[`LED_COMB_LSB +: 4];
    assign page_sel           = page_reg;

    // Activity shaping by rate and per-LED mode
    led_shaper #(
        .N           (NLED),
        .UNIT_CYCLES (UNIT_CYCLES)
    ) led_shaper_i (
        .hclk    (hclk),
        .hresetn (hresetn),
        .cfg     (led_cfg),
        .act_in  (secondary_ind),
        .shaped  (shaped)
    );

    // Combined LED lit by the primary, dark while secondary shapes it off
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pins_reg <= '0;
        end else begin
            for (int i = 0; i < NLED; i++) begin
                pins_reg[i] <= led_cfg.comb_dis[i] ? primary_ind[i]
                                                   : (primary_ind[i] && !shaped[i]);
            end
        end
    end

    assign indicator_pin_a = pins_reg[0];
    assign indicator_pin_b = pins_reg[1];
    assign indicator_pin_c = pins_reg[2];
    assign indicator_pin_d = pins_reg[3];

endmodule

// file: sim/phy_led_regs_checker.sv
// Purpose: Port-level checks of the LED behaviour and page select bank
// Assumes: Sequential single transfers; page changes settle before paged use
// Notes:   Bound to phy_led_regs from the bench top file
`timescale 1ns/1ps
module phy_led_regs_checker (
    input wire logic                  hclk,
    input wire logic                  hresetn,
    input wire logic                  hsel,
    input wire logic [31:0]           haddr,
    input wire logic [1:0]            htrans,
    input wire logic                  hwrite,
    input wire logic [31:0]           hwdata,
    input wire logic                  hready,
    input wire logic                  ext_valid,
    input wire phy_led_pkg::ext_req_s ext_req,
    input wire phy_led_pkg::led_cfg_s led_cfg,
    input wire logic [15:0]           page_sel,
    input wire logic                  hreadyout,
    input wire logic                  hresp,
    input wire logic [31:0]           hrdata
);
    logic take;
    logic mapped;
    // Accepted transfer, and a word address inside the 32 register window
    assign take   = hsel && htrans[1] && hready;
    assign mapped = (haddr[31:7] == 25'h0) && (haddr[1:0] == 2'b00);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Behaviour register write while the main page is selected
    sequence bw_write;
        take && hwrite && mapped && haddr[6:2] == 5'h1e && page_sel == 16'h0000;
    endsequence
    // Register updates at the edge ending the one-cycle data phase
    a_rate_reset_value: assert property ($rose(hresetn) |-> led_cfg.rate == 2'b01)
        else $error("rate field not 01 after reset");
    a_page_reset_zero: assert property ($rose(hresetn) |-> page_sel == 16'h0000)
        else $error("page select not zero after reset");
    a_rate_follows_write: assert property (bw_write |=> ##1
        led_cfg.rate == $past(hwdata[11:10])) else $error("rate field not written");
    a_stretch_follows_write: assert property (bw_write |=> ##1
        led_cfg.stretch_en == $past(hwdata[8:5])) else $error("stretch bits not written");
    a_comb_follows_write: assert property (bw_write |=> ##1
        led_cfg.comb_dis == $past(hwdata[3:0])) else $error("combine bits not written");
    a_page_write_any: assert property (take && hwrite && mapped && haddr[6:2] == 5'h1f
        |=> ##1 page_sel == $past(hwdata[15:0])) else $error("page select not written");
    a_low_index_main: assert property (take && mapped && !haddr[6] |=> ext_valid
        && ext_req.page == 2'd0 && ext_req.index == $past(haddr[6:2]))
        else $error("low index not sent to main page");
    a_page1_stays_inside: assert property (take && mapped && haddr[6]
        && haddr[6:2] != 5'h1f && page_sel == 16'h0001 |=> !ext_valid)
        else $error("page 1 access leaked outside");
    a_page0_upper_main: assert property (take && mapped && haddr[6]
        && haddr[6:2] < 5'h1e && page_sel == 16'h0000 |=> ext_valid && ext_req.page == 2'd0)
        else $error("upper index not sent to main page");
    a_page_read_back: assert property (take && !hwrite && mapped && haddr[6:2] == 5'h1f
        |=> !hreadyout && !hresp ##1 hreadyout && !hresp && hrdata[15:0] == page_sel)
        else $error("page select not read back");
    // Main scenarios reached
    c_behaviour_write: cover property (bw_write);
    c_page1_access: cover property (take && mapped && haddr[6] && page_sel == 16'h0001);
    c_page2_access: cover property (take && mapped && haddr[6] && page_sel == 16'h0002);
endmodule

// file: sim/phy_led_regs_bench.sv
// Purpose: Self-checking bench for the LED behaviour and page select bank
// Assumes: AHB-Lite single word transfers, one at a time
// Notes:   UNIT_CYCLES set to 4 so stretch holds last 8 to 64 cycles
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
    $display("Error t=%0t got %h exp %h", $time, got, exp); end end
module phy_led_regs_bench;
    logic                  hclk, hresetn, hsel, hwrite, hreadyout, ext_valid;
    logic [31:0]           haddr, hwdata, hrdata;
    logic [1:0]            htrans;
    logic [15:0]           ext_rdata, page_sel, rd;
    logic [3:0]            primary_ind, secondary_ind, pins;
    phy_led_pkg::ext_req_s ext_req;
    phy_led_pkg::led_cfg_s led_cfg;
    int                    fails, samples_checked;
    logic                  impl;
    phy_led_regs #(.UNIT_CYCLES(4), .NLED(4)) phy_led_regs_i (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(),
        .hrdata(hrdata), .ext_valid(ext_valid), .ext_req(ext_req), .ext_rdata(ext_rdata),
        .primary_ind(primary_ind), .secondary_ind(secondary_ind), .led_cfg(led_cfg),
        .page_sel(page_sel), .indicator_pin_a(pins[0]), .indicator_pin_b(pins[1]),
        .indicator_pin_c(pins[2]), .indicator_pin_d(pins[3]));
    // Outside registers answer with a pattern naming page and index
    function automatic logic [15:0] ext_val(input logic [1:0] p, input logic [4:0] i);
        return {3'h5, p, 6'h00, i};
    endfunction
    assign ext_rdata = ext_val(ext_req.page, ext_req.index);
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Bounded wait for hready high at a rising edge
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            fails++;
            end_sim();
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a, input logic [15:0] d);
        hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'b10;
        wait_rdy();
        htrans <= 2'b00; hwdata <= {16'h0000, d};
        wait_rdy();
        rd = hrdata[15:0];
    endtask
    task automatic chk_rd(input logic [31:0] a, input logic [15:0] e);
        xfer(1'b0, a, 16'h0000);
        `CHK(rd, e)
    endtask
    // One activity pulse with stretch on, pin A looked at t cycles later
    task automatic led_pulse(input logic [1:0] r, input int t, input logic e);
        xfer(1'b1, 32'h78, {4'h0, r, 1'b0, 4'hf, 5'h00});
        primary_ind <= 4'hf; secondary_ind <= 4'hf;
        @(posedge hclk);
        secondary_ind <= 4'h0;
        repeat (t) @(posedge hclk);
        `CHK(pins[0], e)
        repeat (120) @(posedge hclk);
    endtask
    // Steady activity in blink mode, toggles of pin A counted over 64 cycles
    task automatic blink_count(input logic [1:0] r, input int e);
        int   n;
        logic prev;
        n = 0;
        xfer(1'b1, 32'h78, {4'h0, r, 10'h000});
        primary_ind <= 4'hf;
        secondary_ind <= 4'hf;
        repeat (40) @(posedge hclk);
        prev = pins[0];
        repeat (64) begin
            @(posedge hclk);
            if (pins[0] !== prev) n++;
            prev = pins[0];
        end
        `CHK(n, e)
    endtask
    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
        hwdata = 32'h0; primary_ind = 4'h0; secondary_ind = 4'h0;
        fails = 0; samples_checked = 0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk_rd(32'h78, 16'h0400);
        chk_rd(32'h7c, 16'h0000);
        xfer(1'b1, 32'h78, 16'hffff);
        chk_rd(32'h78, 16'h5def);
        chk_rd(32'h14, ext_val(2'd0, 5'd5));
        chk_rd(32'h80, 16'h0000);
        $display("reset and behaviour test done");
        xfer(1'b1, 32'h7c, 16'h0001);
        chk_rd(32'h7c, 16'h0001);
        for (int i = 16; i < 31; i++) begin
            impl = (i == 18 || i == 19 || i == 20 || i == 23 || i == 29 || i == 30);
            xfer(1'b1, 32'(i * 4), 16'(16'ha000 + i));
            chk_rd(32'(i * 4), impl ? 16'(16'ha000 + i) : 16'h0000);
        end
        chk_rd(32'h0c, ext_val(2'd0, 5'd3));
        xfer(1'b1, 32'h7c, 16'h0002);
        chk_rd(32'h50, ext_val(2'd2, 5'd20));
        chk_rd(32'h7c, 16'h0002);
        xfer(1'b1, 32'h7c, 16'h0000);
        chk_rd(32'h78, 16'h5def);
        chk_rd(32'h50, ext_val(2'd0, 5'd20));
        $display("page test done");
        xfer(1'b1, 32'h78, 16'h000f);
        primary_ind <= 4'b0101; secondary_ind <= 4'hf;
        repeat (3) @(posedge hclk);
        `CHK(pins, 4'b0101)
        led_pulse(2'b11, 4, 1'b0);
        led_pulse(2'b11, 40, 1'b1);
        led_pulse(2'b00, 40, 1'b0);
        led_pulse(2'b00, 100, 1'b1);
        blink_count(2'b01, 4);
        blink_count(2'b10, 8);
        $display("indicator test done");
        // Reset in mid-run with page and rate away from their reset values
        xfer(1'b1, 32'h7c, 16'h0001);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk_rd(32'h78, 16'h0400);
        chk_rd(32'h7c, 16'h0000);
        $display("second reset test done");
        end_sim();
    end
endmodule
bind phy_led_regs phy_led_regs_checker phy_led_regs_checker_i (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .ext_valid(ext_valid), .ext_req(ext_req),
    .led_cfg(led_cfg), .page_sel(page_sel), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata));
